/* verilog/kps_pkg.sv */
package kps_pkg;
    // ------------------------------------------------------------
    // matrix geometry
    // ------------------------------------------------------------
    localparam int KPS_ROWS = 4;
    localparam int KPS_COLS = 4;
    localparam int KPS_KEYS = KPS_ROWS * KPS_COLS;
    localparam logic [1:0] KPS_LAST_ROW = 2'h3;

    // ------------------------------------------------------------
    // register map (word index on the plain port)
    // ------------------------------------------------------------
    localparam logic [2:0] KPS_ADDR_CTRL = 3'h0;
    localparam logic [2:0] KPS_ADDR_MASK = 3'h1;
    localparam logic [2:0] KPS_ADDR_DATA = 3'h2;
    localparam logic [2:0] KPS_ADDR_STAT = 3'h3;
    localparam logic [2:0] KPS_ADDR_IMSK = 3'h4;

    // ------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------
    localparam int KPS_CTRL_DIV_LSB = 0;
    localparam int KPS_CTRL_DIV_MSB = 7;
    localparam int KPS_CTRL_DEB_LSB = 8;
    localparam int KPS_CTRL_DEB_MSB = 11;
    localparam int KPS_CTRL_EN_BIT = 12;
    localparam logic [15:0] KPS_CTRL_WMASK = 16'h1fff;
    localparam logic [15:0] KPS_CTRL_RST = 16'h1309;
    localparam logic [15:0] KPS_MASK_RST = 16'h0000;
    localparam int KPS_STAT_PRESS = 0;
    localparam int KPS_STAT_REL = 1;
    localparam int KPS_STAT_W = 2;

    // ------------------------------------------------------------
    // timing: scan ticks come in whole base periods
    // ------------------------------------------------------------
    localparam int KPS_CLK_MHZ = 125;
    localparam int KPS_BASE_TICK_NS = 1000;
    localparam int KPS_BASE_TICK_CYC = (KPS_BASE_TICK_NS * KPS_CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        KPS_ST_IDLE = 2'b00,
        KPS_ST_SCAN = 2'b01,
        KPS_ST_RELEASE = 2'b10
    } kps_state_t;
endpackage

/* verilog/kps_tick_if.sv */
`timescale 1ns/1ps
interface kps_tick_if;
    logic [7:0] scan_div;
    logic enable;
    logic tick;
    modport ctrl (output scan_div, output enable, input tick);
    modport gen (input scan_div, input enable, output tick);
endinterface

/* verilog/kps_tick_gen.sv */
`timescale 1ns/1ps
module kps_tick_gen
    import kps_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // scan tick carrier
    kps_tick_if.gen tif
);
    localparam logic [6:0] PRE_LAST = 7'(KPS_BASE_TICK_CYC - 1);

    logic [6:0] pre_q;
    logic [7:0] div_q;
    logic tick_q;
    logic pre_wrap;

    assign pre_wrap = (pre_q == PRE_LAST);
    assign tif.tick = tick_q;

    // scan rate is (scan_div + 1) base periods
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_q <= 7'h00;
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (!tif.enable) begin
            pre_q <= 7'h00;
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            pre_q <= pre_wrap ? 7'h00 : pre_q + 7'h01;
            tick_q <= pre_wrap && (div_q >= tif.scan_div);
            if (pre_wrap) begin
                div_q <= (div_q >= tif.scan_div) ? 8'h00 : div_q + 8'h01; // RULE_02
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [15:0] gap_q;
    logic cfg_ok_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_q <= 16'h0000;
            cfg_ok_q <= 1'b0;
        end else begin
            gap_q <= tick_q ? 16'h0000 : gap_q + 16'h0001;
            if (!tif.enable || tif.scan_div != $past(tif.scan_div)) begin
                cfg_ok_q <= 1'b0;
            end else if (tick_q) begin
                cfg_ok_q <= 1'b1;
            end
        end
    end

    property p_tick_period;
        @(posedge clk_i) disable iff (!rst_n_i)
        (tick_q && cfg_ok_q && $stable(tif.scan_div)) |->
            (gap_q == 16'((32'(tif.scan_div) + 1) * KPS_BASE_TICK_CYC - 1));
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("scan tick period wrong"); // RULE_02

    property p_tick_pulse;
        @(posedge clk_i) disable iff (!rst_n_i)
        tick_q |=> !tick_q;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("scan tick longer than one cycle"); // RULE_02
endmodule

/* verilog/kps_keypad_scanner.sv */
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - the matrix is at most four rows by four columns, sixteen keys, key index row*4+column.
// RULE_02 - scan rate and debounce length come from the control register and steer every scan.
// RULE_03 - a masked key is dropped from the scan result and cannot start a detection; here it starts a scan if its column has an unmasked key.
// RULE_04 - after a good scan the data word holds every unmasked pressed key, one bit per key.
// RULE_05 - a column held high reads as all four keys of that column pressed, keys 0,4,8,12 for the first.
// RULE_06 - a press starts an automatic scan and debounce, and only then the key interrupt goes low.
// RULE_07 - the key interrupt stays low until the data word is read, then returns high.
module kps_keypad_scanner
    import kps_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // keypad matrix
    output logic [3:0] row_drive_o,
    input wire logic [3:0] column_lines_i,
    // interrupts
    output logic key_event_irq_n_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // spread one row's column sample into its four key bits
    function automatic logic [15:0] row_bits(input logic [1:0] row, input logic [3:0] cols);
        logic [15:0] res;
        res = 16'h0000;
        res[{row, 2'b00} +: KPS_COLS] = cols; // RULE_01 RULE_05
        return res;
    endfunction

    // with all rows driven, a high column may hit any of its keys
    function automatic logic col_hit(input logic [3:0] cols, input logic [15:0] mask);
        logic hit;
        hit = 1'b0;
        for (int c = 0; c < KPS_COLS; c++) begin
            for (int r = 0; r < KPS_ROWS; r++) begin
                hit = hit | (cols[c] & ~mask[r * KPS_COLS + c]); // RULE_03
            end
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] mask_q;
    logic [15:0] data_q;
    logic [KPS_STAT_W-1:0] stat_q;
    logic [KPS_STAT_W-1:0] imsk_q;
    logic [15:0] rdata_q;
    logic wr_ctrl, wr_mask, wr_imsk, rd_data, rd_stat;
    logic scan_en;
    logic [3:0] deb_cfg;
    logic column_line_first;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == KPS_ADDR_CTRL);
    assign wr_mask = reg_wr_i && (reg_addr_i == KPS_ADDR_MASK);
    assign wr_imsk = reg_wr_i && (reg_addr_i == KPS_ADDR_IMSK);
    assign rd_data = reg_rd_i && (reg_addr_i == KPS_ADDR_DATA);
    assign rd_stat = reg_rd_i && (reg_addr_i == KPS_ADDR_STAT);
    assign scan_en = ctrl_q[KPS_CTRL_EN_BIT];
    assign deb_cfg = ctrl_q[KPS_CTRL_DEB_MSB:KPS_CTRL_DEB_LSB];
    assign column_line_first = column_lines_i[0];

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= KPS_CTRL_RST;
            mask_q <= KPS_MASK_RST;
            imsk_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata_i & KPS_CTRL_WMASK; // RULE_02
            end
            if (wr_mask) begin
                mask_q <= reg_wdata_i;
            end
            if (wr_imsk) begin
                imsk_q <= reg_wdata_i[KPS_STAT_W-1:0];
            end
        end
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                KPS_ADDR_CTRL: rdata_q <= ctrl_q;
                KPS_ADDR_MASK: rdata_q <= mask_q;
                KPS_ADDR_DATA: rdata_q <= data_q;
                KPS_ADDR_STAT: rdata_q <= {{(16 - KPS_STAT_W){1'b0}}, stat_q};
                KPS_ADDR_IMSK: rdata_q <= {{(16 - KPS_STAT_W){1'b0}}, imsk_q};
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------
    // scan tick
    // ------------------------------------------------------------
    kps_tick_if tick_bus ();
    assign tick_bus.scan_div = ctrl_q[KPS_CTRL_DIV_MSB:KPS_CTRL_DIV_LSB];
    assign tick_bus.enable = scan_en;

    kps_tick_gen u_tick (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n),
        .tif(tick_bus.gen)
    );

    logic tick;
    assign tick = tick_bus.tick;

    // ------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------
    kps_state_t state_q;
    logic [1:0] row_q;
    logic [15:0] snap_q;
    logic [15:0] prev_q;
    logic [3:0] deb_q;
    logic first_q;
    logic [3:0] row_drive_q;
    logic [15:0] snap_full;
    logic [15:0] result;
    logic scan_done, report, rel_event;

    assign snap_full = snap_q | row_bits(row_q, column_lines_i);
    assign result = snap_full & ~mask_q; // RULE_03
    assign scan_done = (state_q == KPS_ST_SCAN) && tick && (row_q == KPS_LAST_ROW);
    // a report needs deb_cfg + 1 matching scans after the first one
    assign report = scan_done && (result != 16'h0000) && !first_q &&
                    (result == prev_q) && (deb_q == deb_cfg); // RULE_06
    assign rel_event = (state_q == KPS_ST_RELEASE) && tick && !col_hit(column_lines_i, mask_q);

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= KPS_ST_IDLE;
            row_q <= 2'h0;
            snap_q <= 16'h0000;
            prev_q <= 16'h0000;
            deb_q <= 4'h0;
            first_q <= 1'b1;
        end else if (!scan_en) begin
            state_q <= KPS_ST_IDLE;
            row_q <= 2'h0;
        end else begin
            case (state_q)
                KPS_ST_IDLE: begin
                    if (tick && col_hit(column_lines_i, mask_q)) begin // RULE_03 RULE_06
                        state_q <= KPS_ST_SCAN;
                        row_q <= 2'h0;
                        snap_q <= 16'h0000;
                        first_q <= 1'b1;
                        deb_q <= 4'h0;
                    end
                end
                KPS_ST_SCAN: begin
                    if (tick && row_q != KPS_LAST_ROW) begin
                        snap_q <= snap_full;
                        row_q <= row_q + 2'h1;
                    end else if (scan_done) begin
                        row_q <= 2'h0;
                        snap_q <= 16'h0000;
                        if (result == 16'h0000) begin
                            state_q <= KPS_ST_IDLE;
                        end else if (first_q || result != prev_q) begin
                            // bounce: restart the debounce count
                            prev_q <= result;
                            deb_q <= 4'h0;
                            first_q <= 1'b0;
                        end else if (report) begin
                            state_q <= KPS_ST_RELEASE; // RULE_06
                        end else begin
                            deb_q <= deb_q + 4'h1; // RULE_02
                        end
                    end
                end
                KPS_ST_RELEASE: begin
                    // no new report until every unmasked key is up
                    if (rel_event) begin
                        state_q <= KPS_ST_IDLE;
                    end
                end
                default: state_q <= KPS_ST_IDLE;
            endcase
        end
    end

    // drive lags state by a cycle; ticks are far slower so rows settle
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            row_drive_q <= 4'h0;
        end else if (!scan_en) begin
            row_drive_q <= 4'h0;
        end else if (state_q == KPS_ST_SCAN) begin
            row_drive_q <= 4'(4'h1 << row_q); // RULE_01
        end else begin
            row_drive_q <= 4'hf;
        end
    end
    assign row_drive_o = row_drive_q;

    // ------------------------------------------------------------
    // data word and key interrupt
    // ------------------------------------------------------------
    logic key_irq_n_q;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 16'h0000;
            key_irq_n_q <= 1'b1;
        end else if (report) begin
            data_q <= result; // RULE_04
            key_irq_n_q <= 1'b0; // RULE_06
        end else if (rd_data) begin
            key_irq_n_q <= 1'b1; // RULE_07
        end
    end
    assign key_event_irq_n_o = key_irq_n_q;

    // sticky status, cleared by its read; a new event wins
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= '0;
        end else begin
            stat_q[KPS_STAT_PRESS] <= (stat_q[KPS_STAT_PRESS] && !rd_stat) || report;
            stat_q[KPS_STAT_REL] <= (stat_q[KPS_STAT_REL] && !rd_stat) || rel_event;
        end
    end
    assign irq_o = |(stat_q & imsk_q);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_row_onehot;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (state_q == KPS_ST_SCAN && $past(state_q) == KPS_ST_SCAN && scan_en && $past(scan_en))
            |-> $onehot(row_drive_o);
    endproperty
    a_row_onehot: assert property (p_row_onehot) else $error("scan drives more than one row"); // RULE_01

    property p_mask_excluded;
        @(posedge clk_sys_i) disable iff (!rst_n)
        report |=> ((data_q & $past(mask_q)) == 16'h0000);
    endproperty
    a_mask_excluded: assert property (p_mask_excluded) else $error("masked key reported"); // RULE_03

    property p_data_update;
        @(posedge clk_sys_i) disable iff (!rst_n)
        report |=> (data_q == $past(result)) && !key_event_irq_n_o;
    endproperty
    a_data_update: assert property (p_data_update) else $error("data word not updated"); // RULE_04

    property p_first_column;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (state_q == KPS_ST_SCAN && tick && row_q != KPS_LAST_ROW && column_line_first && scan_en)
            |=> snap_q[{$past(row_q), 2'b00}];
    endproperty
    a_first_column: assert property (p_first_column) else $error("high column not read as pressed"); // RULE_05

    property p_irq_after_debounce;
        @(posedge clk_sys_i) disable iff (!rst_n)
        $fell(key_event_irq_n_o) |-> $past(scan_done) && ($past(deb_q) == $past(deb_cfg));
    endproperty
    a_irq_after_debounce: assert property (p_irq_after_debounce) else $error("irq without debounce"); // RULE_06

    property p_irq_hold;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (!key_event_irq_n_o && !rd_data) |=> !key_event_irq_n_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("key irq released without read"); // RULE_07

    property p_irq_release;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (rd_data && !report) |=> key_event_irq_n_o;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("key irq not released by read"); // RULE_07

    property p_mask_no_start;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (state_q == KPS_ST_IDLE && ((row_bits(2'h0, column_lines_i) | row_bits(2'h1, column_lines_i) |
            row_bits(2'h2, column_lines_i) | row_bits(2'h3, column_lines_i)) & ~mask_q) == 16'h0000)
            |=> state_q != KPS_ST_SCAN;
    endproperty
    a_mask_no_start: assert property (p_mask_no_start) else $error("masked key started a scan"); // RULE_03

    c_report: cover property (@(posedge clk_sys_i) disable iff (!rst_n) report);
    c_bounce: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        scan_done && !first_q && result != prev_q && result != 16'h0000);
    c_release: cover property (@(posedge clk_sys_i) disable iff (!rst_n) rel_event);
    c_read_clear: cover property (@(posedge clk_sys_i) disable iff (!rst_n) !key_event_irq_n_o && rd_data);
endmodule

/* verification/kps_key_matrix_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// passive switch matrix: a closed key joins its row to its column
// ------------------------------------------------------------
module kps_key_matrix_model (
    // matrix side
    input wire logic [3:0] row_drive_i,
    output logic [3:0] column_lines_o,
    // test control
    input wire logic [15:0] closed_keys_i,
    input wire logic [3:0] column_tie_i
);
    // undriven columns rest on column_tie_i, so an open matrix reads the tie value
    always_comb begin
        column_lines_o = column_tie_i;
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 4; c++) begin
                if (row_drive_i[r] && closed_keys_i[r * 4 + c]) begin
                    column_lines_o[c] = 1'b1;
                end
            end
        end
    end
endmodule

/* verification/tb_kps_keypad_scanner.sv */
`timescale 1ns/1ps
module tb_kps_keypad_scanner
    import kps_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys_i;
    logic rst_b_i = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0] row_drive;
    logic [3:0] cols;
    logic irq_n;
    logic irq;
    logic [15:0] keys = 16'h0000;
    logic [3:0] tie = 4'h0;
    int n_errors = 0;
    int n_checks = 0;

    kps_keypad_scanner uut (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata),
        .row_drive_o(row_drive),
        .column_lines_i(cols),
        .key_event_irq_n_o(irq_n),
        .irq_o(irq)
    );

    kps_key_matrix_model mdl (
        .row_drive_i(row_drive),
        .column_lines_o(cols),
        .closed_keys_i(keys),
        .column_tie_i(tie)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // press, time the report against nt ticks of tc cycles, read, release
    task automatic press_check(input logic [15:0] k, input logic [3:0] t, input logic [15:0] exp,
                               input int nt, input int tc, input logic irq_exp);
        int cnt;
        cnt = 0;
        @(posedge clk_sys_i);
        keys <= k;
        tie <= t;
        while (irq_n !== 1'b0 && cnt < (nt + 2) * tc) begin
            @(posedge clk_sys_i);
            #1;
            cnt++;
        end
        if (cnt >= (nt + 2) * tc) begin
            n_errors++;
            summarize();
        end
        chk(16'(cnt >= nt * tc - 2 && cnt <= (nt + 1) * tc + 8), 16'h0001);
        chk(16'(irq), 16'(irq_exp));
        repeat (20) @(posedge clk_sys_i);
        #1;
        chk(16'(irq_n), 16'h0000);
        rd_chk(KPS_ADDR_DATA, exp);
        chk(16'(irq_n), 16'h0001);
        rd_chk(KPS_ADDR_STAT, 16'h0001);
        chk(16'(irq), 16'h0000);
        @(posedge clk_sys_i);
        keys <= 16'h0000;
        tie <= 4'h0;
        // a new press is refused until the release is seen
        repeat (3 * tc) @(posedge clk_sys_i);
        #1;
        // release status feeds the same level interrupt when enabled
        chk(16'(irq), 16'(irq_exp));
        rd_chk(KPS_ADDR_STAT, 16'h0002);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd_chk(KPS_ADDR_CTRL, KPS_CTRL_RST);
        rd_chk(KPS_ADDR_MASK, KPS_MASK_RST);
        rd_chk(KPS_ADDR_DATA, 16'h0000);
        rd_chk(KPS_ADDR_STAT, 16'h0000);
        rd_chk(KPS_ADDR_IMSK, 16'h0000);
        rd_chk(3'h5, 16'h0000);
        chk(16'(irq_n), 16'h0001);
        chk(16'(row_drive), 16'h000f);
        wr(KPS_ADDR_CTRL, 16'he000);
        rd_chk(KPS_ADDR_CTRL, 16'h0000);
        chk(16'(row_drive), 16'h0000);
        wr(KPS_ADDR_MASK, 16'ha5a5);
        rd_chk(KPS_ADDR_MASK, 16'ha5a5);
        wr(KPS_ADDR_DATA, 16'hffff);
        wr(KPS_ADDR_STAT, 16'hffff);
        wr(3'h7, 16'hffff);
        wr(KPS_ADDR_IMSK, 16'hffff);
        rd_chk(KPS_ADDR_DATA, 16'h0000);
        rd_chk(KPS_ADDR_STAT, 16'h0000);
        rd_chk(3'h7, 16'h0000);
        rd_chk(KPS_ADDR_IMSK, 16'h0003);
        wr(KPS_ADDR_MASK, 16'h0000);
        // fastest rate, shortest debounce: report after 8 ticks
        wr(KPS_ADDR_CTRL, 16'h1000);
        press_check(16'h0040, 4'h0, 16'h0040, 8, 125, 1'b1);
        press_check(16'h8001, 4'h0, 16'h8001, 8, 125, 1'b1);
        press_check(16'h0040, 4'h1, 16'h1151, 8, 125, 1'b1);
        wr(KPS_ADDR_MASK, 16'h0040);
        @(posedge clk_sys_i);
        keys <= 16'h0040;
        repeat (2500) @(posedge clk_sys_i);
        rd_chk(KPS_ADDR_STAT, 16'h0000);
        chk(16'(irq_n), 16'h0001);
        press_check(16'h0240, 4'h0, 16'h0200, 8, 125, 1'b1);
        wr(KPS_ADDR_MASK, 16'h0000);
        wr(KPS_ADDR_IMSK, 16'h0000);
        // half rate, debounce 3: report after (3+2)*4 ticks of 250 cycles
        wr(KPS_ADDR_CTRL, 16'h1301);
        press_check(16'h0008, 4'h0, 16'h0008, 20, 250, 1'b0);
        summarize();
    end
endmodule
